// *** rtl/fpt_pkg.sv ***
// Shared constants and carrier types of the fan pulse and tachometer block
package fpt_pkg;

	// ****************************************
	// Register bus shape and map
	// ****************************************
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] OFF_DUTY = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_FREQ = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_TCNT = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_STAT = 5'h10;

	// ****************************************
	// Field layouts and reset values
	// ****************************************
	localparam int DUTY_REG_W = 8;
	localparam int DUTY_FORCE_BIT = 0;
	localparam int DUTY_LSB = 1;
	localparam int DUTY_W = 6;
	localparam int CTRL_W = 4;
	localparam int CTRL_DIV_LSB = 0;
	localparam int CTRL_DIV_W = 3;
	localparam int CTRL_EN_BIT = 3;
	localparam int STAT_NEW_BIT = 0;
	localparam int STAT_OVF_BIT = 1;
	localparam int STAT_PWM_BIT = 2;
	localparam int TCNT_W = 16;
	localparam logic [DUTY_REG_W-1:0] DUTY_RST = 8'h00;
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
	localparam logic [DATA_W-1:0] FREQ_RST = 16'hFFFF;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int PWM_SLOTS = 64;
	localparam int PWM_MIN_PERIOD_NS = 21000;
	localparam int PWM_MAX_PERIOD_NS = 25500000;
	localparam int SLOT_NS = PWM_SLOTS * CLK_PERIOD_NS;
	localparam logic [DATA_W-1:0] PWM_STEP_MIN_CYC =
		DATA_W'((PWM_MIN_PERIOD_NS + SLOT_NS - 1) / SLOT_NS);
	localparam logic [DATA_W-1:0] PWM_STEP_MAX_CYC = DATA_W'(PWM_MAX_PERIOD_NS / SLOT_NS);
	localparam int TACH_BASE_NS = 30520;
	localparam int TACH_BASE_W = 12;
	localparam logic [TACH_BASE_W-1:0] TACH_BASE_CYC =
		TACH_BASE_W'(TACH_BASE_NS / CLK_PERIOD_NS);

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} fpt_bus_req_t;

	typedef struct packed {
		logic [TCNT_W-1:0] count;
		logic update;
		logic overflow;
	} fpt_tach_res_t;

endpackage

// *** rtl/fpt_tach.sv ***
// Tachometer period counter: tach clock ticks between rising tach edges
`timescale 1ns/1ps
`default_nettype none
module fpt_tach (
	input wire logic mclk,
	input wire logic rst,
	input wire logic enable,
	input wire logic tach_lvl,
	input wire logic tick,
	output fpt_pkg::fpt_tach_res_t result
);
	import fpt_pkg::*;

	localparam logic [TCNT_W-1:0] CNT_MAX = '1;

	logic prev_r, prev_nxt;
	logic armed_r, armed_nxt;
	logic [TCNT_W-1:0] cnt_r, cnt_nxt;
	fpt_tach_res_t res_r, res_nxt;
	logic rising;

	always_comb
	begin
		rising = tach_lvl & ~prev_r;
		prev_nxt = tach_lvl;
		armed_nxt = armed_r;
		cnt_nxt = cnt_r;
		res_nxt = res_r;
		res_nxt.update = 1'b0;
		res_nxt.overflow = 1'b0;
		if (!enable)
		begin
			armed_nxt = 1'b0;
			cnt_nxt = '0;
		end
		else if (rising)
		begin
			// First edge only arms; a full period needs two same-polarity edges
			if (armed_r)
			begin
				res_nxt.update = 1'b1;
				res_nxt.count = cnt_r;
			end
			armed_nxt = 1'b1;
			cnt_nxt = '0;
		end
		else if (tick && armed_r && cnt_r != CNT_MAX)
		begin
			// Saturate so a stalled fan reads as slowest, not wrapped
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_r == CNT_MAX - 1'b1)
				res_nxt.overflow = 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			prev_r <= 1'b0;
			armed_r <= 1'b0;
			cnt_r <= '0;
			res_r <= '0;
		end
		else
		begin
			prev_r <= prev_nxt;
			armed_r <= armed_nxt;
			cnt_r <= cnt_nxt;
			res_r <= res_nxt;
		end
	end

	assign result = res_r;

endmodule
`default_nettype wire

// *** rtl/fpt_fan.sv ***
// Fan pulse generator and tachometer measurement with register port
//
// Contract
// - With force-high clear, duty comes from duty register bits 6 to 1.
// - Duty field zero and force clear keeps the fan output low.
// - Force-high bit set keeps the fan output high, duty ignored.
// - Nonzero duty spans 1.56 to 98.44 percent of the period.
// - Period set by registers, 0.021 to 25.5 ms, within two percent.
// - High time reaches from 0.00033 ms up to 25.1 ms.
// - Tach counter clock is 30.52 us times two to the power of the programmed divider field.
`timescale 1ns/1ps
`default_nettype none
module fpt_fan (
	input wire logic mclk,
	input wire logic rst,
	input wire fpt_pkg::fpt_bus_req_t bus_req,
	output logic [fpt_pkg::DATA_W-1:0] rd_data,
	input wire logic fan_tach_in,
	output logic fan_pulse_output
);
	import fpt_pkg::*;

	// ****************************************
	// Tach pin synchroniser
	// ****************************************
	logic tach_s1_r;
	logic tach_s2_r;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			tach_s1_r <= 1'b0;
			tach_s2_r <= 1'b0;
		end
		else
		begin
			tach_s1_r <= fan_tach_in;
			tach_s2_r <= tach_s1_r;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	logic [DUTY_REG_W-1:0] duty_r, duty_nxt;
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [DATA_W-1:0] freq_r, freq_nxt;
	logic [TCNT_W-1:0] tcount_r, tcount_nxt;
	logic new_r, new_nxt;
	logic ovf_r, ovf_nxt;
	logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
	logic pwm_r, pwm_nxt;
	fpt_tach_res_t tach_res;

	always_comb
	begin
		duty_nxt = duty_r;
		ctrl_nxt = ctrl_r;
		freq_nxt = freq_r;
		tcount_nxt = tcount_r;
		new_nxt = new_r;
		ovf_nxt = ovf_r;
		if (bus_req.wr)
		begin
			if (bus_req.addr == OFF_DUTY)
				duty_nxt = bus_req.wdata[DUTY_REG_W-1:0];
			else if (bus_req.addr == OFF_CTRL)
				ctrl_nxt = bus_req.wdata[CTRL_W-1:0];
			else if (bus_req.addr == OFF_FREQ)
				freq_nxt = bus_req.wdata;
			else if (bus_req.addr == OFF_STAT)
			begin
				if (bus_req.wdata[STAT_NEW_BIT])
					new_nxt = 1'b0;
				if (bus_req.wdata[STAT_OVF_BIT])
					ovf_nxt = 1'b0;
			end
		end
		// Hardware set follows the clear so a same-cycle event survives
		if (tach_res.update)
		begin
			tcount_nxt = tach_res.count;
			new_nxt = 1'b1;
		end
		if (tach_res.overflow)
			ovf_nxt = 1'b1;
		rd_data_nxt = '0;
		if (bus_req.rd)
		begin
			if (bus_req.addr == OFF_DUTY)
				rd_data_nxt = DATA_W'(duty_r);
			else if (bus_req.addr == OFF_CTRL)
				rd_data_nxt = DATA_W'(ctrl_r);
			else if (bus_req.addr == OFF_FREQ)
				rd_data_nxt = freq_r;
			else if (bus_req.addr == OFF_TCNT)
				rd_data_nxt = DATA_W'(tcount_r);
			else if (bus_req.addr == OFF_STAT)
				rd_data_nxt = DATA_W'({pwm_r, ovf_r, new_r});
			else
				rd_data_nxt = '0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			duty_r <= DUTY_RST;
			ctrl_r <= CTRL_RST;
			freq_r <= FREQ_RST;
			tcount_r <= '0;
			new_r <= 1'b0;
			ovf_r <= 1'b0;
			rd_data_r <= '0;
		end
		else
		begin
			duty_r <= duty_nxt;
			ctrl_r <= ctrl_nxt;
			freq_r <= freq_nxt;
			tcount_r <= tcount_nxt;
			new_r <= new_nxt;
			ovf_r <= ovf_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	// ****************************************
	// Tach clock time base
	// ****************************************
	logic [TACH_BASE_W-1:0] base_cnt_r, base_cnt_nxt;
	logic [6:0] div_cnt_r, div_cnt_nxt;
	logic [7:0] div_pow;
	logic [6:0] div_lim;
	logic tick_r, tick_nxt;

	always_comb
	begin
		div_pow = 8'h01 << ctrl_r[CTRL_DIV_LSB +: CTRL_DIV_W];
		div_lim = 7'(div_pow - 8'h01);
		base_cnt_nxt = base_cnt_r + 1'b1;
		div_cnt_nxt = div_cnt_r;
		tick_nxt = 1'b0;
		if (!ctrl_r[CTRL_EN_BIT])
		begin
			base_cnt_nxt = '0;
			div_cnt_nxt = '0;
		end
		else if (base_cnt_r == TACH_BASE_CYC - 1'b1)
		begin
			base_cnt_nxt = '0;
			if (div_cnt_r >= div_lim)
			begin
				div_cnt_nxt = '0;
				tick_nxt = 1'b1;
			end
			else
				div_cnt_nxt = div_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			base_cnt_r <= '0;
			div_cnt_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			base_cnt_r <= base_cnt_nxt;
			div_cnt_r <= div_cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	fpt_tach u_tach (
		.mclk(mclk),
		.rst(rst),
		.enable(ctrl_r[CTRL_EN_BIT]),
		.tach_lvl(tach_s2_r),
		.tick(tick_r),
		.result(tach_res)
	);

	// ****************************************
	// Pulse generator
	// ****************************************
	logic [DATA_W-1:0] step_cnt_r, step_cnt_nxt;
	logic [DATA_W-1:0] step_lim;
	logic [DUTY_W-1:0] slot_r, slot_nxt;
	logic [DUTY_W-1:0] duty_act_r, duty_act_nxt;

	always_comb
	begin
		// Clamping keeps every setting inside the legal period range
		if (freq_r < PWM_STEP_MIN_CYC)
			step_lim = PWM_STEP_MIN_CYC;
		else if (freq_r > PWM_STEP_MAX_CYC)
			step_lim = PWM_STEP_MAX_CYC;
		else
			step_lim = freq_r;
		step_cnt_nxt = step_cnt_r + 1'b1;
		slot_nxt = slot_r;
		duty_act_nxt = duty_act_r;
		if (step_cnt_r >= step_lim - 1'b1)
		begin
			step_cnt_nxt = '0;
			slot_nxt = slot_r + 1'b1;
			// New duty taken only at period end, so no runt pulses
			if (slot_r == '1)
				duty_act_nxt = duty_r[DUTY_LSB +: DUTY_W];
		end
		if (duty_r[DUTY_FORCE_BIT])
			pwm_nxt = 1'b1;
		else if (duty_act_r == '0)
			pwm_nxt = 1'b0;
		else
			pwm_nxt = slot_r < duty_act_r;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			step_cnt_r <= '0;
			slot_r <= '0;
			duty_act_r <= '0;
			pwm_r <= 1'b0;
		end
		else
		begin
			step_cnt_r <= step_cnt_nxt;
			slot_r <= slot_nxt;
			duty_act_r <= duty_act_nxt;
			pwm_r <= pwm_nxt;
		end
	end

	assign rd_data = rd_data_r;
	assign fan_pulse_output = pwm_r;

endmodule
`default_nettype wire

// *** test/fpt_fan_chk.sv ***
// Port checker for the fan pulse and tach block
`timescale 1ns/1ps
`default_nettype none
module fpt_fan_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire fpt_pkg::fpt_bus_req_t bus_req,
	input wire logic [fpt_pkg::DATA_W-1:0] rd_data,
	input wire logic fan_tach_in,
	input wire logic fan_pulse_output
);
	import fpt_pkg::*;
	logic [7:0] duty_r;
	logic [15:0] freq_r;
	logic [31:0] age_r, hi_r, lo_r, slot, lim;
	wire wd = bus_req.wr && bus_req.addr == OFF_DUTY;
	wire wf = bus_req.wr && bus_req.addr == OFF_FREQ;
	// Two whole periods after a change, so the new duty has surely been latched
	wire ok = age_r >= lim && !duty_r[0];
	assign slot = freq_r < PWM_STEP_MIN_CYC ? 32'(PWM_STEP_MIN_CYC) :
		freq_r > PWM_STEP_MAX_CYC ? 32'(PWM_STEP_MAX_CYC) : 32'(freq_r);
	assign lim = slot * 128 + 16;
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			duty_r <= DUTY_RST;
			freq_r <= FREQ_RST;
			age_r <= '0;
			hi_r <= '0;
			lo_r <= '0;
		end
		else
		begin
			if (wd)
				duty_r <= bus_req.wdata[7:0];
			if (wf)
				freq_r <= bus_req.wdata;
			age_r <= (wd || wf) ? '0 : age_r + 1;
			hi_r <= fan_pulse_output ? hi_r + 1 : '0;
			lo_r <= fan_pulse_output ? '0 : lo_r + 1;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	AST_OUT_RESET: assert property ($fell(rst) |-> !fan_pulse_output && rd_data == '0)
		else $error("outputs busy after reset");
	AST_RD_QUIET: assert property (!bus_req.rd |=> rd_data == '0)
		else $error("read data without read");
	AST_DUTY_ECHO: assert property (bus_req.rd && bus_req.addr == OFF_DUTY
		|=> rd_data == {8'h00, duty_r})
		else $error("duty readback wrong");
	AST_FORCE_RISE: assert property (wd && bus_req.wdata[0] |-> ##[1:3] fan_pulse_output)
		else $error("force high late");
	AST_FORCE_HOLD: assert property (duty_r[0] [*4] |-> fan_pulse_output)
		else $error("force high dropped");
	AST_ZERO_LOW: assert property (age_r >= lim && duty_r[6:0] == 7'h00 |-> !fan_pulse_output)
		else $error("zero duty not low");
	AST_HIGH_TIME: assert property (ok && $fell(fan_pulse_output) |-> hi_r == duty_r[6:1] * slot)
		else $error("high time wrong");
	AST_LOW_TIME: assert property (ok && $rose(fan_pulse_output)
		|-> lo_r == (64 - duty_r[6:1]) * slot)
		else $error("low time wrong");
endmodule
bind fpt_fan fpt_fan_chk fpt_fan_chk_i (.mclk(mclk), .rst(rst), .bus_req(bus_req),
	.rd_data(rd_data), .fan_tach_in(fan_tach_in), .fan_pulse_output(fan_pulse_output));
`default_nettype wire

// *** test/fpt_fan_model.sv ***
// Behavioural fan: tach pulses with chosen high and low spans
`timescale 1ns/1ps
`default_nettype none
module fpt_fan_model (
	input wire logic mclk,
	input wire logic run,
	input wire logic [31:0] hi_cyc,
	input wire logic [31:0] lo_cyc,
	output logic tach
);
	logic [31:0] ph_r;
	// Bench picks spans of at least three ticks high and one low
	always_ff @(posedge mclk)
	begin
		if (!run)
			ph_r <= '0;
		else if (ph_r + 1 == hi_cyc + lo_cyc)
			ph_r <= '0;
		else
			ph_r <= ph_r + 1;
		tach <= run && ph_r < hi_cyc;
	end
endmodule
`default_nettype wire

// *** test/fpt_fan_tb.sv ***
// Self-checking bench for the fan pulse and tach block
`timescale 1ns/1ps
`default_nettype none
module fpt_fan_tb;
	import fpt_pkg::*;
	logic mclk, rst, run, tach, pwm;
	fpt_bus_req_t req;
	logic [DATA_W-1:0] rd_data;
	logic [31:0] hi_c, lo_c;
	int n_errors, n_checks;
	fpt_fan fpt_fan_i (.mclk(mclk), .rst(rst), .bus_req(req), .rd_data(rd_data),
		.fan_tach_in(tach), .fan_pulse_output(pwm));
	fpt_fan_model fpt_fan_model_i (.mclk(mclk), .run(run), .hi_cyc(hi_c), .lo_cyc(lo_c),
		.tach(tach));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge mclk);
		req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge mclk);
		req.rd <= 1'b0;
		@(negedge mclk);
		chk($sformatf("reg %0h", a), {16'h0000, e}, {16'h0000, rd_data});
	endtask
	// Waits out two periods so the new duty is in force, then times one pulse
	task automatic meas(input int eh, input int el);
		int h, l;
		h = 0;
		l = 0;
		repeat (8000) @(negedge mclk);
		// Skip any pulse already under way so the count starts at a rising edge
		while (pwm === 1'b1) @(negedge mclk);
		while (pwm !== 1'b1) @(negedge mclk);
		while (pwm === 1'b1)
		begin
			h++;
			@(negedge mclk);
		end
		while (pwm !== 1'b1)
		begin
			l++;
			@(negedge mclk);
		end
		chk("high cycles", eh, h);
		chk("low cycles", el, l);
	endtask
	task automatic spin(input logic [15:0] c, input int h, input int l, input logic [15:0] e);
		wr(OFF_CTRL, c);
		hi_c <= h;
		lo_c <= l;
		run <= 1'b1;
		repeat (h + l + 60) @(posedge mclk);
		rd(OFF_TCNT, e);
		rd(OFF_CTRL, c);
		rd(OFF_STAT, 16'h0001);
		wr(OFF_STAT, 16'h0001);
		rd(OFF_STAT, 16'h0000);
		run <= 1'b0;
		wr(OFF_CTRL, 16'h0000);
	endtask
	initial
	begin
		#950000;
		n_errors++;
		finish_test();
	end
	initial
	begin
		rst = 1'b1;
		req = '0;
		run = 1'b0;
		hi_c = '0;
		lo_c = '0;
		n_errors = 0;
		n_checks = 0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		rd(OFF_DUTY, 16'h0000);
		rd(OFF_FREQ, 16'hFFFF);
		rd(OFF_TCNT, 16'h0000);
		wr(5'h14, 16'h00FF);
		rd(5'h14, 16'h0000);
		wr(OFF_DUTY, 16'h0080);
		rd(OFF_DUTY, 16'h0080);
		wr(OFF_FREQ, 16'h0005);
		rd(OFF_FREQ, 16'h0005);
		wr(OFF_DUTY, 16'h0002);
		meas(33, 63 * 33);
		wr(OFF_FREQ, 16'h0028);
		wr(OFF_DUTY, 16'h007E);
		meas(63 * 40, 40);
		wr(OFF_DUTY, 16'h00FF);
		repeat (4) @(negedge mclk);
		chk("forced level", 1, pwm);
		rd(OFF_STAT, 16'h0004);
		wr(OFF_DUTY, 16'h0000);
		repeat (6000) @(negedge mclk);
		chk("idle level", 0, pwm);
		spin(16'h0008, 9156, 6104, 16'h0005);
		spin(16'h0009, 18312, 6104, 16'h0004);
		finish_test();
	end
endmodule
`default_nettype wire
